//--- drp_cpu_model.sv
// Purpose: processor side of the bus
// Assumes: drives at falling edge
// Notes:   released lines show inverted data
`timescale 1ns/1ps
module drp_cpu_model (
   input  logic        clk_sys,
   input  logic        busReady,
   input  logic [7:0]  busRdata,
   output logic        busReq = 1'h0,
   output logic [15:0] busAddr = 16'h0000,
   output logic        busRead = 1'h0,
   output logic [7:0]  busWdata = 8'h00
);
   task automatic acc(input logic [15:0] a, input logic r,
      input logic [7:0] d, output logic [7:0] q, output logic ok);
      ok = 0;
      q = 8'h00;
      @(negedge clk_sys);
      busReq = 1;
      busAddr = a;
      busRead = r;
      busWdata = d;
      // Bounded wait covers stolen refresh cycles
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge clk_sys);
         ok = busReady;
         q = busRdata;
      end
      @(negedge clk_sys);
      busReq = 0;
      busAddr = ~a;
      busWdata = ~d;
   endtask
endmodule

//--- drp_ctrl.sv
// Purpose: decode, address mux, refresh and parity for a 16K DRAM board
// Assumes: bus inputs synchronous to clk_sys, held until ready is seen
// Notes:   memory array modelled inside; one access per request
`timescale 1ns/1ps
`include "drp_defines.svh"
module drp_ctrl #(
   parameter int          REF_CYC    = `DRP_REF_CYC,
   parameter bit          PARITY_FIT = 1'b1,
   parameter int          ROW_BITS   = 7
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [1:0]  baseSel,
   input  wire logic        busReq,
   input  wire logic [15:0] busAddr,
   input  wire logic        busRead,
   input  wire logic [7:0]  busWdata,
   output logic [7:0]       busRdata,
   output logic             busReady,
   output logic             busHold,
   output logic [6:0]       memAddr,
   output logic             memRowStb,
   output logic             memColStb,
   output logic             parityErr,
   output logic             parityErrFlag
);
   localparam int AW = 14;
   // The address split and refresh row assume a 7-bit multiplexed bus
   if (REF_CYC < 8 || ROW_BITS != 7) begin : g_bad_param
      $error("drp_ctrl: unsupported parameter values");
   end

   drp_pkg::drp_state_t state_ff;
   logic [1:0]          cnt_ff;
   logic [31:0]         refCnt_ff;
   logic                refPend_ff;
   logic [6:0]          refRow_ff;
   logic [AW-1:0]       addr_ff;
   logic                read_ff;
   logic [7:0]          wdata_ff;
   logic [8:0]          mem [0:(1<<AW)-1];
   logic [15:0]         base;
   logic                hit;
   logic [16:0]         offs;
   logic [8:0]          word;
   logic                colEnd;
   logic                parMiss;
   logic [8:0]          parChain;

   always_comb begin
      case (baseSel)
         2'h0:    base = `DRP_BASE0;
         2'h1:    base = `DRP_BASE1;
         2'h2:    base = `DRP_BASE2;
         default: base = `DRP_BASE3;
      endcase
      offs = {1'b0, busAddr} - {1'b0, base};
      hit  = (busAddr >= base) && (offs < `DRP_WIN_BYTES);
   end

   // Refresh timer keeps counting so a long access only delays the refresh
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         refCnt_ff  <= 32'h0;
         refPend_ff <= 1'b0;
      end else begin
         if (refCnt_ff == 32'(REF_CYC - 1)) begin
            refCnt_ff  <= 32'h0;
            refPend_ff <= 1'b1;
         end else begin
            refCnt_ff <= refCnt_ff + 32'h1;
            if (state_ff == drp_pkg::DRP_REF && cnt_ff == 2'h0)
               refPend_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_ff <= drp_pkg::DRP_IDLE;
         cnt_ff   <= 2'h0;
         addr_ff  <= '0;
         read_ff  <= 1'b1;
         wdata_ff <= 8'h00;
      end else begin
         case (state_ff)
            drp_pkg::DRP_IDLE: begin
               if (refPend_ff) begin
                  state_ff <= drp_pkg::DRP_REF;
                  cnt_ff   <= 2'(`DRP_ROW_CYC - 1);
               end else if (busReq && hit) begin
                  state_ff <= drp_pkg::DRP_ROW;
                  cnt_ff   <= 2'(`DRP_ROW_CYC - 1);
                  addr_ff  <= offs[AW-1:0];
                  read_ff  <= busRead;
                  wdata_ff <= busWdata;
               end
            end
            drp_pkg::DRP_ROW: begin
               if (cnt_ff == 2'h0) begin
                  state_ff <= drp_pkg::DRP_COL;
                  cnt_ff   <= 2'(`DRP_COL_CYC - 1);
               end else
                  cnt_ff <= cnt_ff - 2'h1;
            end
            drp_pkg::DRP_COL: begin
               if (cnt_ff == 2'h0)
                  state_ff <= drp_pkg::DRP_DONE;
               else
                  cnt_ff <= cnt_ff - 2'h1;
            end
            drp_pkg::DRP_DONE: begin
               // Wait for the request to drop so one request gives one access
               if (!busReq)
                  state_ff <= drp_pkg::DRP_IDLE;
            end
            drp_pkg::DRP_REF: begin
               if (cnt_ff == 2'h0)
                  state_ff <= drp_pkg::DRP_IDLE;
               else
                  cnt_ff <= cnt_ff - 2'h1;
            end
            default: state_ff <= drp_pkg::DRP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         refRow_ff <= 7'h00;
      else if (state_ff == drp_pkg::DRP_REF && cnt_ff == 2'h0)
         refRow_ff <= refRow_ff + 7'h01;
   end

   // Last column cycle: data moves and ready is raised
   assign colEnd  = state_ff == drp_pkg::DRP_COL && cnt_ff == 2'h0;
   assign word    = mem[addr_ff];
   assign parMiss = PARITY_FIT && colEnd && read_ff && (^word);

   // Even parity built bit by bit; the ninth bit evens the ones count
   assign parChain[0] = 1'b0;
   for (genvar i = 0; i < 8; i++) begin : g_par
      assign parChain[i+1] = parChain[i] ^ wdata_ff[i];
   end

   // Row strobe stays up through the column phase, as the array needs
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         memRowStb <= 1'b0;
      else
         memRowStb <= state_ff == drp_pkg::DRP_ROW ||
                      state_ff == drp_pkg::DRP_COL ||
                      state_ff == drp_pkg::DRP_REF;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         memColStb <= 1'b0;
      else
         memColStb <= state_ff == drp_pkg::DRP_COL;
   end

   // Address pins: row half, then column half, refresh row in refresh
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         memAddr <= 7'h00;
      end else begin
         case (state_ff)
            drp_pkg::DRP_ROW: memAddr <= addr_ff[6:0];
            drp_pkg::DRP_COL: memAddr <= addr_ff[13:7];
            drp_pkg::DRP_REF: memAddr <= refRow_ff;
            default:          memAddr <= memAddr;
         endcase
      end
   end

   // Only writes store; a refresh never touches the array contents
   always_ff @(posedge clk_sys) begin
      if (colEnd && !read_ff)
         mem[addr_ff] <= {PARITY_FIT ? parChain[8] : 1'b0, wdata_ff};
   end

   // Read data holds until the next read completes
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         busRdata <= 8'h00;
      else if (colEnd && read_ff)
         busRdata <= word[7:0];
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         busReady <= 1'b0;
      else
         busReady <= colEnd;
   end

   // A level, so the processor side sees the whole stolen cycle
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         busHold <= 1'b0;
      else
         busHold <= refPend_ff || state_ff == drp_pkg::DRP_REF;
   end

   // Unknown parity of a never-written byte takes the quiet branch
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         parityErr <= 1'b0;
      else if (parMiss)
         parityErr <= 1'b1;
      else
         parityErr <= 1'b0;
   end

   // Sticky until reset so software can find a past error
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         parityErrFlag <= 1'b0;
      else if (parMiss)
         parityErrFlag <= 1'b1;
   end
endmodule

//--- drp_ctrl_monitor.sv
// Purpose: port checker for drp_ctrl
// Assumes: default walk timing, parity fitted
// Notes:   bound to every drp_ctrl
`timescale 1ns/1ps
module drp_ctrl_monitor (
   input logic clk_sys,
   input logic rstn,
   input logic busReq,
   input logic busRead,
   input logic busReady,
   input logic busHold,
   input logic memRowStb,
   input logic memColStb,
   input logic parityErr,
   input logic parityErrFlag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_ready_pulse: assert property (busReady |=> !busReady)
      else $error("ready held too long");
   a_ready_req: assert property (busReady |-> busReq && memColStb)
      else $error("ready without request");
   a_ready_after: assert property ($fell(memColStb) |-> $past(busReady))
      else $error("no ready after column");
   a_col_row: assert property ($rose(memColStb) |->
      memRowStb && $past(memRowStb, 2))
      else $error("column not after row");
   a_col_len: assert property ($rose(memColStb) |=>
      memColStb ##1 !memColStb)
      else $error("column phase length");
   a_err_read: assert property (parityErr |-> busReady && busRead)
      else $error("error outside read");
   a_err_flag: assert property (parityErr |=> parityErrFlag)
      else $error("flag not set");
   a_flag_keep: assert property (parityErrFlag |=> parityErrFlag)
      else $error("flag dropped");
   a_hold_ref: assert property ($rose(busHold) |->
      ##[0:6] (memRowStb && !memColStb))
      else $error("refresh did not start");
endmodule
bind drp_ctrl drp_ctrl_monitor drp_ctrl_monitor_inst (.clk_sys, .rstn,
   .busReq, .busRead, .busReady, .busHold, .memRowStb, .memColStb,
   .parityErr, .parityErrFlag);

//--- drp_defines.svh
// Purpose: constants for the dynamic RAM board controller
// Assumes: 40 MHz system clock, 25 ns period
// Notes:   offsets are bus byte addresses; times in ns
// Functional notes
// - Switch selects one of four bases
// - Decode 16K window enables control logic
// - Drive row then column address multiplexing
// - Read/write line picks read or write
// - Steal one cycle every 32 us
// - Refresh counter address replaces bus address
// - Parity optional; absent means no errors
// - Write stores even parity bit
// - Read mismatch raises error signal and flag
`ifndef DRP_DEFINES_SVH
`define DRP_DEFINES_SVH
`define DRP_BASE0        16'h0000
`define DRP_BASE1        16'h4000
`define DRP_BASE2        16'h8000
`define DRP_BASE3        16'hA000
`define DRP_WIN_BYTES    17'h04000
`define DRP_REF_NS       32000
`define DRP_CLK_NS       25
`define DRP_REF_CYC      (`DRP_REF_NS / `DRP_CLK_NS)
`define DRP_ROW_CYC      2
`define DRP_COL_CYC      2
`endif

//--- drp_pkg.sv
// Purpose: types for the dynamic RAM board controller
// Assumes: nothing
// Notes:   one-hot sequencer states
package drp_pkg;
   typedef enum logic [4:0] {
      DRP_IDLE = 5'h01,
      DRP_ROW  = 5'h02,
      DRP_COL  = 5'h04,
      DRP_DONE = 5'h08,
      DRP_REF  = 5'h10
   } drp_state_t;
endpackage

//--- tb.sv
// Purpose: self-checking bench for drp_ctrl
// Assumes: short refresh interval
// Notes:   random data from a fixed LFSR
`timescale 1ns/1ps
module tb;
   logic        clk_sys = 0;
   logic        rstn = 0;
   logic [1:0]  baseSel = 2'h0;
   logic        busReq, busRead, busReady, busHold, parityErrFlag, ok;
   logic [15:0] busAddr, a;
   logic [7:0]  busWdata, busRdata, q;
   logic [31:0] lf = 32'h77B9;
   logic        memRowStb, memColStb, colSeen = 0, inRow = 0, hadCol = 0;
   logic [6:0]  memAddr, prevAddr = 7'h00, refRowExp = 7'h00;
   logic [15:0] off = 16'h0000;
   int          n_fail = 0, n_tests = 0, cyc = 0;
   realtime     t;
   drp_ctrl #(.REF_CYC(16)) drp_ctrl_inst (.clk_sys, .rstn, .baseSel,
      .busReq, .busAddr, .busRead, .busWdata, .busRdata, .busReady,
      .busHold, .memAddr, .memRowStb, .memColStb, .parityErr(),
      .parityErrFlag);
   drp_cpu_model drp_cpu_model_inst (.clk_sys, .busReady, .busRdata,
      .busReq, .busAddr, .busRead, .busWdata);
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [15:0] base(input logic [1:0] s);
      return s == 0 ? 16'h0000 : s == 1 ? 16'h4000 : s == 2 ? 16'h8000
         : 16'hA000;
   endfunction
   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial forever #12.5 clk_sys = ~clk_sys;
   // Row half is shown the cycle before the column strobe rises
   always @(posedge clk_sys) begin
      if (rstn && memColStb && !colSeen) begin
         chk("row addr", {9'h0, off[6:0]}, {9'h0, prevAddr});
         chk("col addr", {9'h0, off[13:7]}, {9'h0, memAddr});
      end
      if (rstn && !memRowStb && inRow && !hadCol) begin
         chk("refresh row", {9'h0, refRowExp}, {9'h0, prevAddr});
         refRowExp <= refRowExp + 7'h01;
      end
      colSeen  <= memColStb;
      inRow    <= memRowStb;
      hadCol   <= memRowStb && (hadCol || memColStb);
      prevAddr <= memAddr;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   initial begin
      repeat (2) @(negedge clk_sys);
      rstn = 1;
      for (int s = 0; s < 12; s++) begin
         baseSel = s[1:0];
         lf = nx(lf);
         a = base(s[1:0]) + {2'h0, lf[13:0]};
         off = a - base(s[1:0]);
         drp_cpu_model_inst.acc(a, 0, lf[21:14], q, ok);
         chk("write ok", 1, {15'h0, ok});
         drp_cpu_model_inst.acc(a, 1, 8'h00, q, ok);
         chk("read data", {8'h0, lf[21:14]}, {8'h0, q});
         drp_cpu_model_inst.acc(a + 16'h4000, 1, 8'h00, q, ok);
         chk("outside ok", 0, {15'h0, ok});
         $display("base test %0d done", s);
      end
      @(posedge busHold);
      t = $realtime;
      @(posedge busHold);
      chk("refresh gap", 16, 16'(int'(($realtime - t) / 25)));
      chk("error flag", 0, {15'h0, parityErrFlag});
      $display("refresh test done");
      test_done;
   end
endmodule
